// >>> logic/bfs_pkg.sv
/*
 Constants, types and carriers of the buck fault supervisor.
 Assumes one 10 MHz clock; voltages are unsigned codes of 1 mV per step.
*/
package bfs_pkg;
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int MV_W = 12;
   localparam int CNT_W = 12;
   localparam int TRIM_W = 8;
   localparam int TICK_US = 1;
   localparam int TICK_CYC = CLK_FREQ_HZ / 1_000_000 * TICK_US;
   localparam int SOFT_SLEW_MV_PER_US = 1;
   localparam int DVS_SLEW_MV_PER_US = 8;
   localparam int PG_DELAY_US = 200;
   localparam int PG_DELAY_CYC = CLK_FREQ_HZ / 1_000_000 * PG_DELAY_US;
   localparam int UV_QUAL_US = 200;
   localparam int UV_QUAL_CYC = CLK_FREQ_HZ / 1_000_000 * UV_QUAL_US;
   localparam int INTEG_HOLD_US = 20;
   localparam int INTEG_HOLD_CYC = CLK_FREQ_HZ / 1_000_000 * INTEG_HOLD_US;
   localparam logic [MV_W:0] UV_MARGIN_MV = 13'h00C8;
   localparam logic [MV_W:0] OV_MARGIN_MV = 13'h012C;
   localparam logic [MV_W-1:0] LS_CUTOFF_MV = 12'h064;
   localparam logic signed [TRIM_W-1:0] TRIM_LIMIT_MV = 8'sh37;
   localparam logic [MV_W-1:0] ZERO_MV = 12'h000;

   typedef logic [MV_W-1:0] bfs_mv_t;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_SOFT_START,
      ST_PG_WAIT,
      ST_RUN,
      ST_SOFT_STOP,
      ST_FAULT
   } bfs_state_e;

   typedef struct packed {
      logic err_cmp;
      logic thermal_trip;
      logic high_side_off;
      logic low_side_off;
   } bfs_sense_s;
endpackage

// >>> logic/bfs_supervisor.sv
/*
 Sequencing, power-good, fault latch and gate interlock of a buck controller.
 Assumes synchronous voltage codes, one clock and power-on reset on I_RST.
*/
`timescale 1ns/100ps
module bfs_supervisor (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_ENABLE,
   input wire logic I_BIAS_OK,
   input wire logic I_OVP_ENABLE,
   input wire logic I_SKIP_MODE,
   input wire bfs_pkg::bfs_mv_t I_REFERENCE_INPUT_LEVEL,
   input wire bfs_pkg::bfs_mv_t I_FEEDBACK_SENSE,
   input wire bfs_pkg::bfs_sense_s I_SENSE,
   input wire logic I_PWM_HIGH,
   input wire logic I_PWM_LOW,
   input wire logic signed [bfs_pkg::TRIM_W-1:0] I_INTEG_REQ,
   output logic [bfs_pkg::MV_W-1:0] O_TARGET,
   output logic O_HIGH_SIDE_GATE,
   output logic O_LOW_SIDE_GATE,
   output logic O_POWER_GOOD_FLAG_OUT,
   output logic O_POWER_GOOD_FLAG_OE,
   output logic O_INTEG_SHORT,
   output logic signed [bfs_pkg::TRIM_W-1:0] O_INTEG_TRIM,
   output logic O_FAULT,
   output logic O_FORCED_PWM
);
   bfs_pkg::bfs_state_e state_q, state_d;
   bfs_pkg::bfs_sense_s sense_m_q, sense_q;
   logic err_prev_q, ovp_q, uv_stop_q, seen_q, hs_prev_q, ls_prev_q;
   logic [bfs_pkg::CNT_W-1:0] tick_cnt_q, pg_cnt_q, uv_cnt_q, integ_cnt_q;
   bfs_pkg::bfs_mv_t target_q, goal, step, target_d;
   logic [bfs_pkg::MV_W:0] fb_w, tg_w;
   logic tick, active, switching, under, over_raw, over, uv_done, thermal;
   logic err_edge, settled, down_step, integ_done, start_ok, fault_evt;
   logic stopping, forced, cmd_hs, cmd_ls, hs_d, ls_d, pg_oe_d;
   logic signed [bfs_pkg::TRIM_W-1:0] trim_d;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         sense_m_q <= '0;
         sense_q <= '0;
         err_prev_q <= 1'b0;
      end else begin
         sense_m_q <= I_SENSE;
         sense_q <= sense_m_q;
         err_prev_q <= sense_q.err_cmp;
      end
   end

   assign thermal = sense_q.thermal_trip;
   assign err_edge = sense_q.err_cmp != err_prev_q;
   assign tick = tick_cnt_q == bfs_pkg::CNT_W'(bfs_pkg::TICK_CYC - 1);
   assign active = state_q != bfs_pkg::ST_OFF && state_q != bfs_pkg::ST_FAULT;
   assign switching = active;
   assign stopping = state_q == bfs_pkg::ST_SOFT_STOP;
   assign fb_w = {1'b0, I_FEEDBACK_SENSE};
   assign tg_w = {1'b0, target_q};
   assign under = fb_w + bfs_pkg::UV_MARGIN_MV < tg_w;
   assign over_raw = fb_w > tg_w + bfs_pkg::OV_MARGIN_MV;
   assign over = I_OVP_ENABLE && over_raw && active;
   assign uv_done = under
      && uv_cnt_q == bfs_pkg::CNT_W'(bfs_pkg::UV_QUAL_CYC - 1);
   assign start_ok = I_ENABLE && I_BIAS_OK && !O_FAULT && !thermal;
   assign fault_evt = active && (over || (thermal && I_BIAS_OK) || uv_done);

   assign goal = stopping ? bfs_pkg::ZERO_MV : I_REFERENCE_INPUT_LEVEL;
   assign step = (state_q == bfs_pkg::ST_SOFT_START || stopping)
      ? bfs_pkg::MV_W'(bfs_pkg::SOFT_SLEW_MV_PER_US)
      : bfs_pkg::MV_W'(bfs_pkg::DVS_SLEW_MV_PER_US);
   assign target_d = !active ? bfs_pkg::ZERO_MV
      : !tick ? target_q
      : (target_q < goal) ? ((goal - target_q > step) ? target_q + step : goal)
      : ((target_q - goal > step) ? target_q - step : goal);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         bfs_pkg::ST_OFF: begin
            if (start_ok) begin
               state_d = bfs_pkg::ST_SOFT_START;
            end
         end
         bfs_pkg::ST_SOFT_START: begin
            if (!I_ENABLE) begin
               state_d = bfs_pkg::ST_SOFT_STOP;
            end else if (target_q == I_REFERENCE_INPUT_LEVEL) begin
               state_d = bfs_pkg::ST_PG_WAIT;
            end
         end
         bfs_pkg::ST_PG_WAIT: begin
            if (!I_ENABLE || uv_done) begin
               state_d = bfs_pkg::ST_SOFT_STOP;
            end else if (pg_cnt_q ==
                  bfs_pkg::CNT_W'(bfs_pkg::PG_DELAY_CYC - 1)) begin
               state_d = bfs_pkg::ST_RUN;
            end
         end
         bfs_pkg::ST_RUN: begin
            if (!I_ENABLE || uv_done) begin
               state_d = bfs_pkg::ST_SOFT_STOP;
            end
         end
         bfs_pkg::ST_SOFT_STOP: begin
            if (target_q == bfs_pkg::ZERO_MV) begin
               state_d = bfs_pkg::ST_OFF;
            end
         end
         bfs_pkg::ST_FAULT: begin
            if (!I_ENABLE) begin
               state_d = bfs_pkg::ST_OFF;
            end
         end
      endcase
      // overvoltage or thermal stop at once
      if (active && (over || thermal)) begin
         state_d = bfs_pkg::ST_FAULT;
      end
      if (!I_BIAS_OK) begin
         state_d = bfs_pkg::ST_OFF;
      end
   end

   assign down_step = state_q == bfs_pkg::ST_RUN && I_SKIP_MODE
      && I_REFERENCE_INPUT_LEVEL < target_q;
   assign settled = target_q == I_REFERENCE_INPUT_LEVEL;
   assign integ_done = seen_q
      && integ_cnt_q == bfs_pkg::CNT_W'(bfs_pkg::INTEG_HOLD_CYC - 1);
   assign trim_d = (O_INTEG_SHORT || down_step) ? '0
      : (I_INTEG_REQ > bfs_pkg::TRIM_LIMIT_MV) ? bfs_pkg::TRIM_LIMIT_MV
      : (I_INTEG_REQ < -bfs_pkg::TRIM_LIMIT_MV) ? -bfs_pkg::TRIM_LIMIT_MV
      : I_INTEG_REQ;

   // skip in soft-start, forced in soft-stop
   assign forced = stopping
      || (state_q != bfs_pkg::ST_SOFT_START && !I_SKIP_MODE);
   assign cmd_hs = switching && !over && !thermal && I_BIAS_OK && I_PWM_HIGH;
   // both gates low on thermal trip unless overvoltage, which turns the low gate on
   assign cmd_ls = over ? 1'b1
      : (!I_BIAS_OK || thermal) ? 1'b0
      : (state_q == bfs_pkg::ST_FAULT) ? ovp_q
      : (!switching) ? 1'b0
      : (stopping && uv_stop_q && target_q < bfs_pkg::LS_CUTOFF_MV) ? 1'b0
      : forced ? !I_PWM_HIGH
      : I_PWM_LOW;
   assign hs_d = cmd_hs && !cmd_ls && !O_LOW_SIDE_GATE && !ls_prev_q
      && sense_q.low_side_off;
   assign ls_d = cmd_ls && !O_HIGH_SIDE_GATE && !hs_prev_q
      && sense_q.high_side_off;
   assign pg_oe_d = !(state_q == bfs_pkg::ST_RUN && state_d == bfs_pkg::ST_RUN
      && !under && !over_raw);

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_q <= bfs_pkg::ST_OFF;
         tick_cnt_q <= '0;
         target_q <= bfs_pkg::ZERO_MV;
      end else begin
         state_q <= state_d;
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
         target_q <= target_d;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pg_cnt_q <= '0;
         uv_cnt_q <= '0;
      end else begin
         pg_cnt_q <= (state_q == bfs_pkg::ST_PG_WAIT) ? pg_cnt_q + 1'b1 : '0;
         uv_cnt_q <= (under && (state_q == bfs_pkg::ST_PG_WAIT
            || state_q == bfs_pkg::ST_RUN) && !uv_done) ? uv_cnt_q + 1'b1 : '0;
      end
   end

   // fault latch, set wins over clear
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_FAULT <= 1'b0;
         ovp_q <= 1'b0;
         uv_stop_q <= 1'b0;
      end else begin
         O_FAULT <= fault_evt || (O_FAULT && I_ENABLE);
         ovp_q <= over || (ovp_q && I_ENABLE);
         uv_stop_q <= (active && uv_done) || (uv_stop_q && active);
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_INTEG_SHORT <= 1'b0;
         seen_q <= 1'b0;
         integ_cnt_q <= '0;
      end else begin
         O_INTEG_SHORT <= active && (down_step || (O_INTEG_SHORT && !integ_done));
         seen_q <= !down_step && O_INTEG_SHORT && !integ_done
            && (seen_q || (settled && err_edge));
         integ_cnt_q <= (seen_q && !down_step && !integ_done)
            ? integ_cnt_q + 1'b1 : '0;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_HIGH_SIDE_GATE <= 1'b0;
         O_LOW_SIDE_GATE <= 1'b0;
         hs_prev_q <= 1'b0;
         ls_prev_q <= 1'b0;
         O_POWER_GOOD_FLAG_OE <= 1'b1;
         O_POWER_GOOD_FLAG_OUT <= 1'b0;
         O_INTEG_TRIM <= '0;
         O_FORCED_PWM <= 1'b0;
         O_TARGET <= bfs_pkg::ZERO_MV;
      end else begin
         O_HIGH_SIDE_GATE <= hs_d;
         O_LOW_SIDE_GATE <= ls_d;
         hs_prev_q <= O_HIGH_SIDE_GATE;
         ls_prev_q <= O_LOW_SIDE_GATE;
         O_POWER_GOOD_FLAG_OE <= pg_oe_d;
         O_POWER_GOOD_FLAG_OUT <= 1'b0;
         O_INTEG_TRIM <= trim_d;
         O_FORCED_PWM <= forced && switching;
         O_TARGET <= target_d;
      end
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   sequence seq_down_step;
      down_step && active;
   endsequence
   sequence seq_hold_end;
      integ_done && !down_step;
   endsequence

   AST_SLEW_STEP: assert property (
      active && !tick |=> $stable(target_q))
      else $error("Target moved off a slew tick");
   AST_SOFT_RAMP: assert property (
      state_q == bfs_pkg::ST_SOFT_START && tick && state_d == state_q
      && target_q < I_REFERENCE_INPUT_LEVEL |=> target_q == $past(target_q) + 1)
      else $error("Soft-start ramp not one step per tick");
   AST_INTEG_SHORT: assert property (
      seq_down_step |=> O_INTEG_SHORT ##1 O_INTEG_SHORT)
      else $error("Integrator not shorted on downward step");
   AST_INTEG_HOLD: assert property (
      seq_hold_end |=> !O_INTEG_SHORT)
      else $error("Integrator short not released after hold");
   AST_TRIM_LIMIT: assert property (
      O_INTEG_TRIM <= bfs_pkg::TRIM_LIMIT_MV
      && O_INTEG_TRIM >= -bfs_pkg::TRIM_LIMIT_MV)
      else $error("Integrator trim out of range");
   AST_PG_LOW: assert property (
      state_q != bfs_pkg::ST_RUN |=> O_POWER_GOOD_FLAG_OE)
      else $error("Power-good released outside run");
   AST_OVP: assert property (
      over |=> !O_HIGH_SIDE_GATE && O_FAULT && O_POWER_GOOD_FLAG_OE)
      else $error("Overvoltage response missing");
   AST_UV_FAULT: assert property (
      uv_done && active |=> O_FAULT && state_q == bfs_pkg::ST_SOFT_STOP
      || state_q == bfs_pkg::ST_FAULT || state_q == bfs_pkg::ST_OFF)
      else $error("Undervoltage not latched");
   AST_THERMAL: assert property (
      thermal && active && I_BIAS_OK |=> O_FAULT && !O_HIGH_SIDE_GATE
      && !O_LOW_SIDE_GATE)
      else $error("Thermal trip response missing");
   AST_INTERLOCK: assert property (
      !(O_HIGH_SIDE_GATE && O_LOW_SIDE_GATE))
      else $error("Both gates on");
endmodule

// >>> tb/bfs_switch_model.sv
/*
 Model of the power switch stage that reports gate-off sense.
 Assumes gate drives from the supervisor; sense lags each gate fall.
*/
`timescale 1ns/100ps
module bfs_switch_model #(
   parameter int OFF_DLY = 2
) (
   input wire logic i_clk,
   input wire logic i_high_gate,
   input wire logic i_low_gate,
   output logic o_high_off,
   output logic o_low_off
);
   logic [3:0] hi_cnt_q = 4'hF;
   logic [3:0] lo_cnt_q = 4'hF;
   always_ff @(posedge i_clk) begin
      if (i_high_gate) hi_cnt_q <= 4'h0;
      else if (hi_cnt_q != 4'hF) hi_cnt_q <= hi_cnt_q + 4'h1;
      if (i_low_gate) lo_cnt_q <= 4'h0;
      else if (lo_cnt_q != 4'hF) lo_cnt_q <= lo_cnt_q + 4'h1;
   end
   assign o_high_off = (hi_cnt_q >= OFF_DLY);
   assign o_low_off = (lo_cnt_q >= OFF_DLY);
endmodule

// >>> tb/tb_bfs_supervisor.sv
/*
 Self-checking bench of the buck fault supervisor.
 Assumes the switch stage model and a 10 MHz clock.
*/
`timescale 1ns/100ps
module tb_bfs_supervisor;
   logic clk, rst, en, bias, ovp_en, skip, err, therm, pwm_h, pwm_l;
   bfs_pkg::bfs_mv_t ref_lvl, fb;
   logic signed [7:0] integ, trim;
   logic [11:0] tgt;
   logic hs, ls, pg_oe, pg_out, shrt, flt, fpwm, hs_off, ls_off;
   bfs_pkg::bfs_sense_s sense;
   int failures, total_checks, cycles;
   assign sense = {err, therm, hs_off, ls_off};
   bfs_supervisor dut_u (.I_CLK(clk), .I_RST(rst), .I_ENABLE(en),
      .I_BIAS_OK(bias), .I_OVP_ENABLE(ovp_en), .I_SKIP_MODE(skip),
      .I_REFERENCE_INPUT_LEVEL(ref_lvl), .I_FEEDBACK_SENSE(fb),
      .I_SENSE(sense), .I_PWM_HIGH(pwm_h), .I_PWM_LOW(pwm_l),
      .I_INTEG_REQ(integ), .O_TARGET(tgt), .O_HIGH_SIDE_GATE(hs),
      .O_LOW_SIDE_GATE(ls), .O_POWER_GOOD_FLAG_OUT(pg_out),
      .O_POWER_GOOD_FLAG_OE(pg_oe), .O_INTEG_SHORT(shrt),
      .O_INTEG_TRIM(trim), .O_FAULT(flt), .O_FORCED_PWM(fpwm));
   bfs_switch_model part_u (.i_clk(clk), .i_high_gate(hs),
      .i_low_gate(ls), .o_high_off(hs_off), .o_low_off(ls_off));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic look;
      @(negedge clk);
   endtask
   task automatic wait_tgt(input logic [11:0] v, input int lim);
      int i;
      i = 0;
      while (tgt !== v && i < lim) begin
         look;
         i++;
      end
      chk("target", v, tgt);
   endtask
   task automatic startup;
      @(posedge clk);
      en <= 1'b1;
      cyc(100);
      look;
      chk("pg_oe soft start", 12'h001, pg_oe);
      chk("forced soft start", 12'h000, fpwm);
      chk("target rising", 12'h001, tgt > 12'h000);
      wait_tgt(ref_lvl, 3000);
      cyc(1990);
      look;
      chk("pg_oe wait", 12'h001, pg_oe);
      cyc(20);
      look;
      chk("pg_oe run", 12'h000, pg_oe);
   endtask
   task automatic test_reset;
      look;
      chk("rst pg_oe", 12'h001, pg_oe);
      chk("rst pg_out", 12'h000, pg_out);
      chk("rst gates", 12'h000, {hs, ls});
      chk("rst fault", 12'h000, flt);
      chk("rst target", 12'h000, tgt);
      $display("test reset done");
   endtask
   task automatic test_down_step;
      startup;
      chk("trim clamp", 12'h037, 12'(trim));
      @(posedge clk);
      ref_lvl <= ref_lvl - 12'h010;
      cyc(2);
      look;
      chk("short on", 12'h001, shrt);
      chk("trim shorted", 12'h000, 12'(trim));
      cyc(7);
      look;
      chk("slew", 12'h001, tgt >= ref_lvl + 12'h008);
      wait_tgt(ref_lvl, 40);
      cyc(20);
      err <= ~err;
      cyc(150);
      look;
      chk("short hold", 12'h001, shrt);
      cyc(80);
      look;
      chk("short off", 12'h000, shrt);
      $display("test down step done");
   endtask
   task automatic test_ovp;
      @(posedge clk);
      fb <= ref_lvl + 12'h012D;
      cyc(8);
      look;
      chk("ovp gates", 12'h001, {hs, ls});
      chk("ovp fault", 12'h001, flt);
      chk("ovp pg", 12'h001, pg_oe);
      @(posedge clk);
      en <= 1'b0;
      fb <= ref_lvl;
      cyc(4);
      look;
      chk("ovp clear", 12'h000, flt);
      $display("test ovp done");
   endtask
   task automatic test_uv;
      startup;
      @(posedge clk);
      fb <= 12'h000;
      cyc(3);
      look;
      chk("uv pg", 12'h001, pg_oe);
      chk("uv early", 12'h000, flt);
      cyc(2010);
      look;
      chk("uv fault", 12'h001, flt);
      chk("uv forced", 12'h001, fpwm);
      wait_tgt(12'h070, 3000);
      chk("uv low gate above", 12'h001, ls);
      wait_tgt(12'h050, 400);
      chk("uv low gate cut", 12'h000, ls);
      chk("pg out low", 12'h000, pg_out);
      wait_tgt(12'h000, 1000);
      chk("uv low gate", 12'h000, ls);
      cyc(50);
      look;
      chk("held off", 12'h000, tgt);
      @(posedge clk);
      en <= 1'b0;
      fb <= ref_lvl;
      cyc(4);
      look;
      chk("uv clear", 12'h000, flt);
      $display("test uv done");
   endtask
   task automatic test_thermal;
      startup;
      @(posedge clk);
      therm <= 1'b1;
      cyc(6);
      look;
      chk("hot fault", 12'h001, flt);
      chk("hot gates", 12'h000, {hs, ls});
      chk("hot pg", 12'h001, pg_oe);
      @(posedge clk);
      en <= 1'b0;
      cyc(2);
      en <= 1'b1;
      cyc(20);
      look;
      chk("hot refused", 12'h000, tgt);
      @(posedge clk);
      therm <= 1'b0;
      cyc(40);
      look;
      chk("cool restart", 12'h001, tgt != 12'h000);
      $display("test thermal done");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         final_report;
      end
   end
   initial begin
      {rst, bias, ovp_en, skip, pwm_l} = 5'h1F;
      {en, err, therm, pwm_h} = 4'h0;
      ref_lvl = 12'h0FA;
      fb = 12'h0FA;
      integ = 8'sh7F;
      failures = 0;
      total_checks = 0;
      cycles = 0;
      cyc(16);
      rst <= 1'b0;
      test_reset;
      test_down_step;
      test_ovp;
      test_uv;
      test_thermal;
      final_report;
   end
endmodule
